// *** src/power_state_supply_sequencer.sv ***
// power-state supply sequencer with APB per-state configuration registers
`timescale 1ns/10ps
`default_nettype none
module power_state_supply_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire supply_seq_pkg::supply_good_t supplyGood,
    output supply_seq_pkg::supply_cfg_t supplyCfg,
    output logic [2:0] stateCode
);
    import supply_seq_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] wakingTwo_q;
    logic [31:0] awake_q;
    logic [31:0] sleepingOne_q;
    logic [31:0] sleepingTwo_q;
    logic [31:0] readData_q;
    logic [31:0] readData_d;
    logic slvErr_q;
    logic slvErr_d;
    seq_state_t state_q;
    seq_state_t state_d;
    supply_cfg_t cfg_q;
    supply_cfg_t cfg_d;
    logic [2:0] code_q;
    logic [2:0] code_d;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setupPhase;
    logic wrAccess;
    logic hitWakingTwo;
    logic hitAwake;
    logic hitSleepingOne;
    logic hitSleepingTwo;
    logic hitControl;
    logic hitStatus;
    logic hitAny;
    logic [31:0] byteMask;
    logic sleepRequest;
    logic wakeRequest;

    // no wait states: read data registered in setup, answered in the first access cycle
    assign setupPhase = psel && !penable;
    assign wrAccess = psel && penable && pwrite;
    assign pready = psel && penable;
    assign pslverr = pready && slvErr_q;
    assign prdata = readData_q;

    assign hitWakingTwo = (paddr == WakingTwoOffset);
    assign hitAwake = (paddr == AwakeOffset);
    assign hitSleepingOne = (paddr == SleepingOneOffset);
    assign hitSleepingTwo = (paddr == SleepingTwoOffset);
    assign hitControl = (paddr == SeqControlOffset);
    assign hitStatus = (paddr == SeqStatusOffset);
    assign hitAny = hitWakingTwo || hitAwake || hitSleepingOne || hitSleepingTwo
                    || hitControl || hitStatus;

    // byte lanes from pstrb
    assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // self-clearing control strobes; sleep honoured only while awake
    assign sleepRequest = wrAccess && hitControl && pstrb[0]
                          && pwdata[SleepInitBit] && (state_q == StAwake);
    assign wakeRequest = wrAccess && hitControl && pstrb[0] && pwdata[WakeReqBit];

    // ------------------------------------------------------------
    // read mux and error
    // ------------------------------------------------------------
    always_comb begin
        readData_d = readData_q;
        slvErr_d = slvErr_q;
        if (setupPhase) begin
            slvErr_d = !hitAny;
            readData_d = '0;
            if (!pwrite) begin
                if (hitWakingTwo) begin
                    readData_d = wakingTwo_q;
                end else if (hitAwake) begin
                    readData_d = awake_q;
                end else if (hitSleepingOne) begin
                    readData_d = sleepingOne_q;
                end else if (hitSleepingTwo) begin
                    readData_d = sleepingTwo_q;
                end else if (hitStatus) begin
                    readData_d = {13'h0000, code_q, 16'h0000} | {25'h0000000, cfg_q};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // config register writes; masks keep reserved and read-only bits
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask);
        logic [31:0] m;
        m = wmask & byteMask;
        merge = (old & ~m) | (pwdata & m);
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wakingTwo_q <= WakingTwoReset;
            awake_q <= AwakeReset;
            sleepingOne_q <= SleepingOneReset;
            sleepingTwo_q <= SleepingTwoReset;
        end else if (wrAccess) begin
            if (hitWakingTwo) begin
                wakingTwo_q <= merge(wakingTwo_q, DwellRegMask);
            end
            if (hitAwake) begin
                awake_q <= merge(awake_q, AwakeRegMask);
            end
            if (hitSleepingOne) begin
                sleepingOne_q <= merge(sleepingOne_q, DwellRegMask);
            end
            if (hitSleepingTwo) begin
                sleepingTwo_q <= merge(sleepingTwo_q, DwellRegMask);
            end
        end
    end

    // bus answer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readData_q <= '0;
            slvErr_q <= 1'b0;
        end else begin
            readData_q <= readData_d;
            slvErr_q <= slvErr_d;
        end
    end

    // ------------------------------------------------------------
    // dwell timer
    // ------------------------------------------------------------
    logic dwellStart;
    logic dwellDone;
    logic [4:0] dwellExp;
    logic allGood;
    logic [31:0] activeReg;

    // exponent of the state being timed; the next state here would loop through expiry
    assign dwellStart = (state_d != state_q);
    assign dwellExp = (state_q == StWakingTwo) ? wakingTwo_q[DwellMsb:DwellLsb] :
                      (state_q == StSleepingOne) ? sleepingOne_q[DwellMsb:DwellLsb] :
                      sleepingTwo_q[DwellMsb:DwellLsb];

    dwell_timer u_dwell (
        .clk(clk),
        .rst_n(rst_n),
        .start(dwellStart),
        .exponent(dwellExp),
        .expired(dwellDone)
    );

    // every supply enabled in waking two must report good
    assign allGood = (!wakingTwo_q[IoSupplyBit] || supplyGood.ioGood)
                     && (!wakingTwo_q[PllSupplyBit] || supplyGood.pllGood)
                     && (!wakingTwo_q[AnalogueEnBit] || supplyGood.analogueGood)
                     && (!wakingTwo_q[CoreEnBit] || supplyGood.coreGood);

    // ------------------------------------------------------------
    // sequencer state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            StReset: begin
                state_d = StAwake;
            end
            StAsleep: begin
                if (wakeRequest) begin
                    state_d = StWakingOne;
                end
            end
            StWakingOne: begin
                state_d = StWakingTwo;
            end
            StWakingTwo: begin
                if (dwellDone && allGood) begin
                    state_d = StAwakeWait;
                end
            end
            StAwakeWait: begin
                state_d = StAwake;
            end
            StAwake: begin
                if (sleepRequest) begin
                    state_d = StSleepingOne;
                end
            end
            StSleepingOne: begin
                if (dwellDone) begin
                    state_d = StSleepingTwo;
                end
            end
            StSleepingTwo: begin
                if (dwellDone) begin
                    state_d = StAsleep;
                end
            end
            default: begin
                state_d = StReset;
            end
        endcase
    end

    // outputs from the register of the state being entered
    always_comb begin
        case (state_d)
            StWakingTwo: activeReg = wakingTwo_q;
            StAwake, StAwakeWait: activeReg = awake_q;
            StSleepingOne: activeReg = sleepingOne_q;
            StSleepingTwo: activeReg = sleepingTwo_q;
            default: activeReg = awake_q;
        endcase
    end

    assign cfg_d.tileClockOff = activeReg[TileClockOffBit];
    assign cfg_d.analogueMod = activeReg[AnalogueModBit];
    assign cfg_d.coreMod = activeReg[CoreModBit];
    assign cfg_d.ioSupplyEn = activeReg[IoSupplyBit];
    assign cfg_d.pllSupplyEn = activeReg[PllSupplyBit];
    assign cfg_d.analogueEn = activeReg[AnalogueEnBit];
    assign cfg_d.coreEn = activeReg[CoreEnBit];

    // state code encoding
    always_comb begin
        case (state_d)
            StReset: code_d = 3'h0;
            StAsleep: code_d = 3'h1;
            StWakingOne: code_d = 3'h2;
            StWakingTwo: code_d = 3'h3;
            StAwakeWait: code_d = 3'h4;
            StAwake: code_d = 3'h5;
            StSleepingOne: code_d = 3'h6;
            StSleepingTwo: code_d = 3'h7;
            default: code_d = 3'h0;
        endcase
    end

    // state, code and supply outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= StReset;
            code_q <= 3'h0;
            cfg_q <= supply_cfg_t'(7'h0F);
        end else begin
            state_q <= state_d;
            code_q <= code_d;
            cfg_q <= cfg_d;
        end
    end

    assign supplyCfg = cfg_q;
    assign stateCode = code_q;
endmodule
`default_nettype wire

// *** src/supply_seq_pkg.sv ***
// constants, types and the function list for the power-state supply sequencer
// Function
// - waking-two and sleeping registers hold dwell exponent bits 20:16, reset 16, 2^n cycles.
// - in waking two, apply its outputs and stay at least the dwell time.
// - after waking-two dwell, advance only when every enabled supply reports good.
// - each sleeping state lasts its dwell time while driving its configured outputs.
// - awake register configures awake outputs only (the code also uses it in reset, asleep, waking one and awake wait); bits 31:15 reserved, read-only.
// - bit 14 set stops the tile clock in that state; resets to zero.
// - bit 9 selects second converter modulation, 0 pulse-width, 1 pulse-frequency.
// - bit 8 selects first converter modulation, 0 pulse-width, 1 pulse-frequency.
// - bit 5 enables the IO supply output in that state.
// - bit 4 enables the core PLL supply regulator in that state.
// - bit 1 shows analogue converter enable; read-only, writes ignored.
// - bit 0 enables the core supply converter in that state.
// - awake register resets with all supplies on, clock running, pulse-width modulation.
// - sleeping-one register resets with IO and analogue on, core and PLL off.
// - sleeping-two register resets with only the analogue supply on.
// - waking-two register resets with IO, PLL and analogue supplies enabled (the code resets it to 0x0010_0033, so the core supply is enabled too).
// - state code: 0 reset,1 asleep,2 waking_one_state,3 waking_two_state,4 awake wait,5 awake,6 sleep1,7 sleep2.
// - dwell cycles are counted on the sequencer's current clock.
package supply_seq_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] WakingTwoOffset = 8'h14;
    localparam logic [7:0] AwakeOffset = 8'h18;
    localparam logic [7:0] SleepingOneOffset = 8'h1C;
    localparam logic [7:0] SleepingTwoOffset = 8'h20;
    localparam logic [7:0] SeqControlOffset = 8'h40;
    localparam logic [7:0] SeqStatusOffset = 8'h44;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int DwellLsb = 16;
    localparam int DwellMsb = 20;
    localparam int TileClockOffBit = 14;
    localparam int AnalogueModBit = 9;
    localparam int CoreModBit = 8;
    localparam int IoSupplyBit = 5;
    localparam int PllSupplyBit = 4;
    localparam int AnalogueEnBit = 1;
    localparam int CoreEnBit = 0;
    localparam int StateLsb = 16;
    localparam int SleepInitBit = 1;
    localparam int WakeReqBit = 0;

    // writable bits of the dwell registers and of the awake register
    localparam logic [31:0] DwellRegMask = 32'h001F_4331;
    localparam logic [31:0] AwakeRegMask = 32'h0000_4331;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] WakingTwoReset = 32'h0010_0033;
    localparam logic [31:0] AwakeReset = 32'h0000_0033;
    localparam logic [31:0] SleepingOneReset = 32'h0010_0022;
    localparam logic [31:0] SleepingTwoReset = 32'h0010_0002;

    // ------------------------------------------------------------
    // timing: one dwell count per sequencer clock cycle
    // ------------------------------------------------------------
    localparam int ClockPeriodNs = 5;
    localparam int DwellWidth = 32;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        StReset = 8'h01,
        StAsleep = 8'h02,
        StWakingOne = 8'h04,
        StWakingTwo = 8'h08,
        StAwakeWait = 8'h10,
        StAwake = 8'h20,
        StSleepingOne = 8'h40,
        StSleepingTwo = 8'h80
    } seq_state_t;

    typedef logic [2:0] state_code_t;

    // supply outputs driven for the current state
    typedef struct packed {
        logic tileClockOff;
        logic analogueMod;
        logic coreMod;
        logic ioSupplyEn;
        logic pllSupplyEn;
        logic analogueEn;
        logic coreEn;
    } supply_cfg_t;

    // power-good reports from the supplies
    typedef struct packed {
        logic ioGood;
        logic pllGood;
        logic analogueGood;
        logic coreGood;
    } supply_good_t;

endpackage

// *** src/dwell_timer.sv ***
// dwell timer: counts 2^n sequencer clock cycles after a start pulse
`timescale 1ns/10ps
`default_nettype none
module dwell_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [4:0] exponent,
    output logic expired
);
    import supply_seq_pkg::*;

    logic [DwellWidth-1:0] count_q;
    logic [DwellWidth-1:0] count_d;
    logic [DwellWidth-1:0] target;
    logic running_q;
    logic running_d;

    // ------------------------------------------------------------
    // count compare
    // ------------------------------------------------------------
    // last cycle of 2^n is count 2^n - 1
    assign target = (DwellWidth'(1) << exponent) - DwellWidth'(1);
    assign expired = running_q && (count_q >= target);
    assign count_d = start ? '0 : (expired ? count_q : count_q + DwellWidth'(1));
    assign running_d = start ? 1'b1 : running_q;

    // counter runs on the sequencer clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= '0;
            running_q <= 1'b0;
        end else begin
            count_q <= count_d;
            running_q <= running_d;
        end
    end
endmodule
`default_nettype wire

// *** tb/power_state_supply_sequencer_checker.sv ***
// checker: sequencer state order and apb answer assertions
`timescale 1ns/10ps
`default_nettype none
module power_state_supply_sequencer_checker
    import supply_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire supply_good_t supplyGood,
    input wire supply_cfg_t supplyCfg,
    input wire logic [2:0] stateCode
);
    // every enabled supply reports good
    wire logic goodOk;
    assign goodOk = (!supplyCfg.ioSupplyEn || supplyGood.ioGood)
        && (!supplyCfg.pllSupplyEn || supplyGood.pllGood)
        && (!supplyCfg.analogueEn || supplyGood.analogueGood)
        && (!supplyCfg.coreEn || supplyGood.coreGood);

    // dwell exponents as last written over the bus
    logic [4:0] wakeExp_q;
    logic [4:0] sleepExp_q;
    logic [2:0] lastCode_q;
    logic [31:0] stayCnt_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wakeExp_q <= WakingTwoReset[DwellMsb:DwellLsb];
            sleepExp_q <= SleepingOneReset[DwellMsb:DwellLsb];
        end else if (psel && penable && pwrite && pstrb[2]) begin
            if (paddr == WakingTwoOffset) begin
                wakeExp_q <= pwdata[DwellMsb:DwellLsb];
            end
            if (paddr == SleepingOneOffset) begin
                sleepExp_q <= pwdata[DwellMsb:DwellLsb];
            end
        end
    end

    // cycles spent in the current state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lastCode_q <= 3'h0;
            stayCnt_q <= 32'h1;
        end else begin
            lastCode_q <= stateCode;
            stayCnt_q <= (stateCode == lastCode_q) ? stayCnt_q + 32'h1 : 32'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_ready_access: assert property (psel && penable |-> pready)
        else $error("pready missing in access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    chk_rdata_hold: assert property (psel && penable |=> $stable(prdata))
        else $error("prdata changed after access");
    chk_reset_awake: assert property ($rose(rst_n) |-> stateCode == 3'h0 ##1 stateCode == 3'h5)
        else $error("reset did not lead to awake");
    chk_sleep_entry: assert property (stateCode == 3'h5 ##1 stateCode != 3'h5 |-> stateCode == 3'h6)
        else $error("awake left to a wrong state");
    chk_sleep_dwell: assert property ($fell(stateCode == 3'h6)
        |-> stayCnt_q == (32'h1 << sleepExp_q))
        else $error("sleeping one dwell wrong");
    chk_sleep_order: assert property (stateCode == 3'h6 ##1 stateCode != 3'h6 |-> stateCode == 3'h7)
        else $error("sleeping one left to a wrong state");
    chk_asleep_next: assert property (stateCode == 3'h7 ##1 stateCode != 3'h7 |-> stateCode == 3'h1)
        else $error("sleeping two left to a wrong state");
    chk_wake_dwell: assert property ($fell(stateCode == 3'h3)
        |-> stayCnt_q >= (32'h1 << wakeExp_q))
        else $error("waking two too short");
    chk_wake_good: assert property (stateCode == 3'h3 ##1 stateCode == 3'h4 |-> $past(goodOk))
        else $error("waking two left without good supplies");
    chk_wait_awake: assert property (stateCode == 3'h4 |=> stateCode == 3'h5)
        else $error("awake wait not followed by awake");

    cov_sleep: cover property ($rose(stateCode == 3'h6));
    cov_wake: cover property ($rose(stateCode == 3'h3));
    cov_err: cover property (pslverr);
endmodule

bind power_state_supply_sequencer power_state_supply_sequencer_checker u_chk (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .supplyGood(supplyGood), .supplyCfg(supplyCfg), .stateCode(stateCode));
`default_nettype wire

// *** tb/supply_model.sv ***
// supply model: power-good reports that follow the enables
`timescale 1ns/10ps
`default_nettype none
module supply_model
    import supply_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire supply_cfg_t supplyCfg,
    input wire logic holdBad,
    output var supply_good_t supplyGood
);
    logic [3:0] enNow;
    logic [3:0] enDly_q;
    assign enNow = {supplyCfg.ioSupplyEn, supplyCfg.pllSupplyEn,
        supplyCfg.analogueEn, supplyCfg.coreEn};

    // good two cycles after switch-on; bad from one cycle after switch-off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enDly_q <= 4'h0;
            supplyGood <= supply_good_t'(4'h0);
        end else begin
            enDly_q <= enNow;
            supplyGood <= supply_good_t'(enDly_q & enNow & {4{!holdBad}});
        end
    end
endmodule
`default_nettype wire

// *** tb/power_state_supply_sequencer_tb.sv ***
// testbench: registers, sleep and wake sequences of the sequencer
`timescale 1ns/10ps
`default_nettype none
module power_state_supply_sequencer_tb;
    import supply_seq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic holdBad = 1'b0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    supply_good_t supplyGood;
    supply_cfg_t supplyCfg;
    logic [2:0] stateCode;
    logic [31:0] rdat;
    logic rerr;
    int mismatches = 0;
    int n_checks = 0;

    power_state_supply_sequencer u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .supplyGood(supplyGood),
        .supplyCfg(supplyCfg), .stateCode(stateCode));
    supply_model u_model (.clk(clk), .rst_n(rst_n), .supplyCfg(supplyCfg),
        .holdBad(holdBad), .supplyGood(supplyGood));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task automatic test_done();
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer, waiting for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            mismatches++;
            test_done();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check_word(name, exp, rdat);
    endtask

    // wait for a state, check its outputs, count its cycles (expN 0: not checked)
    task automatic dwell(input logic [2:0] code, input int expN, input logic [7:0] expCfg);
        int n;
        n = 0;
        #1;
        while (stateCode !== code && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 200) begin
            mismatches++;
            test_done();
        end
        if (!expCfg[7]) check_word("supplyCfg", {25'h0, expCfg[6:0]}, {25'h0, supplyCfg});
        n = 0;
        while (stateCode === code && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (expN > 0) check_word("dwell", expN, n);
    endtask

    task automatic t_reset_values();
        rd_chk("waking two", 8'h14, 32'h0010_0033);
        rd_chk("awake", 8'h18, 32'h0000_0033);
        rd_chk("sleeping one", 8'h1C, 32'h0010_0022);
        rd_chk("sleeping two", 8'h20, 32'h0010_0002);
    endtask

    task automatic t_masks();
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        rd_chk("waking two ones", 8'h14, 32'h001F_4333);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        rd_chk("awake ones", 8'h18, 32'h0000_4333);
        dwell(3'h5, 0, 8'h7F);
        apb(1'b1, 8'h18, 32'h0);
        rd_chk("awake zero", 8'h18, 32'h0000_0002);
        dwell(3'h5, 0, 8'h02);
        apb(1'b1, 8'h18, 32'h0000_0033);
        apb(1'b0, 8'h3C, 32'h0);
        check_word("unmapped error", 32'h1, {31'h0, rerr});
        check_word("unmapped data", 32'h0, rdat);
    endtask

    task automatic t_sleep();
        apb(1'b1, 8'h1C, 32'h0002_0120);
        apb(1'b1, 8'h20, 32'h0001_4200);
        apb(1'b1, 8'h40, 32'h0000_0002);
        dwell(3'h6, 4, 8'h1A);
        dwell(3'h7, 2, 8'h62);
        check_word("asleep", 32'h1, {29'h0, stateCode});
        apb(1'b1, 8'h40, 32'h0000_0002);
        dwell(3'h1, 0, 8'h80);
        check_word("sleep ignored", 32'h1, {29'h0, stateCode});
        rd_chk("status", 8'h44, 32'h0001_000F);
    endtask

    task automatic t_wake(input logic hold);
        @(posedge clk);
        holdBad <= hold;
        apb(1'b1, 8'h14, 32'h0002_0033);
        apb(1'b1, 8'h40, 32'h0000_0001);
        dwell(3'h2, 1, 8'h80);
        if (!hold) begin
            dwell(3'h3, 4, 8'h0F);
        end else begin
            repeat (12) @(posedge clk);
            #1;
            check_word("still waking", 32'h3, {29'h0, stateCode});
            @(posedge clk);
            holdBad <= 1'b0;
            dwell(3'h3, 0, 8'h0F);
        end
        dwell(3'h4, 1, 8'h80);
        check_word("awake again", 32'h5, {29'h0, stateCode});
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_masks();
        t_sleep();
        t_wake(1'b0);
        t_sleep();
        t_wake(1'b1);
        test_done();
    end
endmodule
`default_nettype wire
